// file: dtr_readout.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - Trace enable cannot be set while secured
// - Range field selects address window filter
// - Filter only in detail mode; bounds unenabled
// - Mode field: flow, dedup, detail, PC-only
// - Alignment field: end, begin, middle, reserved
// - Bits 7:6 need unsecured disarmed; 5:0 disarmed
// - Pairing readable always, writable only disarmed
// - C/D pairing: separate, inside, outside range
// - Reserved C/D code acts as separate
// - A/B pairing mirrors the C/D scheme
// - Reserved A/B code acts as separate
// - Window gives 64-bit line as four halfwords
// - Qualifying window read advances read pointer
// - Arming locks the buffer against reading
// - Disarmed aligned window write unlocks, keeps data
// - Reads need unlocked, unsecured, disarmed, enabled
// - Bad or armed reads return zero, pointer kept
// - Buffer contents survive all but power-on
// - Arming clears full flag; otherwise POR only
module dtr_readout #(
  parameter int LINES = 64 // Trace buffer depth in lines
) (
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic reset_n, // Power-on reset, async, active low
  input wire logic [9:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic securePin, // Chip secured level, asynchronous
  input wire logic sessionEnd, // Capture logic ends session, pulse
  input wire logic fullSet, // Capture logic wrapped buffer, pulse
  input wire logic capWrite, // Capture store strobe
  input wire logic [$clog2(LINES)-1:0] capAddr, // Capture line address
  input wire logic [63:0] capData, // Capture line data
  input wire logic cmpA, // Comparator A hit
  input wire logic cmpB, // Comparator B hit
  input wire logic cmpC, // Comparator C hit
  input wire logic cmpD, // Comparator D hit
  input wire logic abInside, // Address inside A..B
  input wire logic cdInside, // Address inside C..D
  input wire logic atOrAboveC, // Address at or above C
  input wire logic atOrBelowD, // Address at or below D
  output logic [3:0] matchChannel, // Match channels 3..0
  output logic filterPass, // Access passes range filter
  output logic traceEnable, // Tracing session enabled
  output logic [1:0] traceMode, // Trace mode field
  output logic [1:0] triggerAlign, // Trigger alignment field
  output logic armed // Session armed
);
  localparam int LW = $clog2(LINES); // Line address width
  localparam int PW = LW + 2; // Halfword pointer width

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic secureMeta; // First synchroniser stage
  logic secured; // Synchronised secured state
  logic locked; // Buffer read lock
  logic fullFlag; // Buffer full flag
  logic [7:0] traceCtrl; // Trace control register
  logic [7:0] pairing; // Comparator pairing register
  logic [PW-1:0] readPtr; // Halfword read pointer
  logic ack; // Bus answer cycle
  logic [63:0] traceMem [LINES]; // Trace line storage, never reset

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [7:0] idx; // Register index
  logic wordAcc; // Aligned 16-bit access
  logic doWrite; // Write takes effect this edge
  logic doRead; // Read completes this edge
  logic winReadOk; // Window read qualifies
  logic armWrite; // Arm bit written to one
  logic unlockWrite; // Window write that unlocks

  // Register index from the byte address; low two bits ignored
  assign idx = avs_address[9:2];
  // Only the two low byte lanes together make an aligned word
  assign wordAcc = (avs_byteenable == dtr_pkg::BE_LOW_HALF);
  // Effects land only at the answer edge of a transfer
  assign doWrite = avs_write && ack;
  assign doRead = avs_read && ack;
  // Every qualifier but the byte-lane check is a registered state of this cycle
  assign winReadOk = wordAcc && !locked && !secured && !armed && traceCtrl[dtr_pkg::BIT_TRACE_EN];
  // Arming locks the buffer and clears the full flag
  assign armWrite = doWrite && idx == dtr_pkg::IDX_SESSION && avs_writedata[dtr_pkg::BIT_ARM];
  // Unlock needs an aligned word write while disarmed
  assign unlockWrite = doWrite && idx == dtr_pkg::IDX_WINDOW && wordAcc && !armed;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle per access, answer in the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // Wait drops in the answer cycle only
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  // ----------------------------------------
  // Secure synchroniser
  // ----------------------------------------
  // Two stages; reads as secured until the pin level is seen
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secureMeta <= 1'b1;
      secured <= 1'b1;
    end else begin
      secureMeta <= securePin;
      secured <= secureMeta;
    end
  end

  // ----------------------------------------
  // Arm bit
  // ----------------------------------------
  // Software write wins over a session end in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b0;
    end else if (doWrite && idx == dtr_pkg::IDX_SESSION) begin
      armed <= avs_writedata[dtr_pkg::BIT_ARM];
    end else if (sessionEnd) begin
      armed <= 1'b0;
    end
  end

  // ----------------------------------------
  // Buffer lock
  // ----------------------------------------
  // Arming locks, an unlock write releases
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      locked <= 1'b1;
    end else if (armWrite) begin
      locked <= 1'b1;
    end else if (unlockWrite) begin
      locked <= 1'b0;
    end
  end

  // ----------------------------------------
  // Buffer full flag
  // ----------------------------------------
  // Capture wrap wins over the clear by arming
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fullFlag <= 1'b0;
    end else if (fullSet) begin
      fullFlag <= 1'b1;
    end else if (armWrite) begin
      fullFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Trace control register
  // ----------------------------------------
  // Guarded field writes; secured forces the enable low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      traceCtrl <= dtr_pkg::RST_TRACE_CTRL;
    end else if (doWrite && idx == dtr_pkg::IDX_TRACE_CTRL && avs_byteenable[0]) begin
      if (!secured && !armed) begin
        traceCtrl[7:6] <= avs_writedata[7:6];
      end
      if (!armed) begin
        traceCtrl[5:0] <= avs_writedata[5:0];
      end
    end else if (secured) begin
      traceCtrl[dtr_pkg::BIT_TRACE_EN] <= 1'b0;
    end
  end

  // Mode and alignment straight from the register; enable also gated by secured
  assign traceEnable = traceCtrl[dtr_pkg::BIT_TRACE_EN] && !secured;
  assign traceMode = traceCtrl[dtr_pkg::POS_MODE +: 2];
  assign triggerAlign = traceCtrl[dtr_pkg::POS_ALIGN +: 2];

  // ----------------------------------------
  // Comparator pairing register
  // ----------------------------------------
  // Writes taken only while disarmed
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pairing <= dtr_pkg::RST_PAIRING;
    end else if (doWrite && idx == dtr_pkg::IDX_PAIRING && avs_byteenable[0] && !armed) begin
      pairing <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------
  // Match channel mapping
  // ----------------------------------------
  // Registered so the channels are clean flip-flop outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      matchChannel <= 4'h0;
    end else begin
      // A/B pair drives channels 1 and 0; code 11 acts as separate
      unique case (dtr_pkg::dtr_pair_t'(pairing[dtr_pkg::POS_AB +: 2]))
        dtr_pkg::PAIR_INSIDE: matchChannel[1:0] <= {1'b0, abInside};
        dtr_pkg::PAIR_OUTSIDE: matchChannel[1:0] <= {1'b0, !abInside};
        default: matchChannel[1:0] <= {cmpB, cmpA};
      endcase
      // C/D pair drives channels 3 and 2; code 11 acts as separate
      unique case (dtr_pkg::dtr_pair_t'(pairing[dtr_pkg::POS_CD +: 2]))
        dtr_pkg::PAIR_INSIDE: matchChannel[3:2] <= {1'b0, cdInside};
        dtr_pkg::PAIR_OUTSIDE: matchChannel[3:2] <= {1'b0, !cdInside};
        default: matchChannel[3:2] <= {cmpD, cmpC};
      endcase
    end
  end

  // ----------------------------------------
  // Range filter
  // ----------------------------------------
  // Bounds apply only in detail mode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      filterPass <= 1'b1;
    end else if (dtr_pkg::dtr_mode_t'(traceMode) != dtr_pkg::MODE_DETAIL) begin
      filterPass <= 1'b1;
    end else begin
      // Address window chosen by the range field
      unique case (dtr_pkg::dtr_range_t'(traceCtrl[dtr_pkg::POS_RANGE +: 2]))
        dtr_pkg::RANGE_ALL: filterPass <= 1'b1;
        dtr_pkg::RANGE_TO_D: filterPass <= atOrBelowD;
        dtr_pkg::RANGE_FROM_C: filterPass <= atOrAboveC;
        dtr_pkg::RANGE_C_D: filterPass <= atOrAboveC && atOrBelowD;
      endcase
    end
  end

  // ----------------------------------------
  // Trace storage
  // ----------------------------------------
  // No reset: contents survive every reset but are unknown at power-up
  always_ff @(posedge sys_clk) begin
    // Capture side writes whole lines
    if (capWrite) begin
      traceMem[capAddr] <= capData;
    end
  end

  // ----------------------------------------
  // Read pointer
  // ----------------------------------------
  // Halfword pointer; wraps after the last line
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readPtr <= PW'(dtr_pkg::RST_PTR);
    end else if (unlockWrite) begin
      readPtr <= PW'(dtr_pkg::RST_PTR);
    end else if (doRead && idx == dtr_pkg::IDX_WINDOW && winReadOk) begin
      readPtr <= readPtr + PW'(1);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Loaded in the wait cycle, stands in the answer cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= 32'h0000_0000;
      unique case (idx)
        dtr_pkg::IDX_SESSION: begin
          avs_readdata[dtr_pkg::BIT_ARM] <= armed;
          avs_readdata[dtr_pkg::BIT_SECURE] <= secured;
          avs_readdata[dtr_pkg::BIT_LOCKED] <= locked;
        end
        dtr_pkg::IDX_STATUS: avs_readdata[dtr_pkg::BIT_FULL] <= fullFlag;
        dtr_pkg::IDX_TRACE_CTRL: avs_readdata[7:0] <= traceCtrl;
        dtr_pkg::IDX_PAIRING: avs_readdata[7:0] <= pairing;
        // Refused window reads keep the zero loaded above
        dtr_pkg::IDX_WINDOW: begin
          if (winReadOk) begin
            avs_readdata[15:0] <= traceMem[readPtr[PW-1:2]][16*readPtr[1:0] +: 16];
          end
        end
        // Unmapped indices read as zero
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // All checks run on the system clock, quiet in reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Enable bit cannot go from clear to set while secured
  secure_blocks_en_a: assert property (
    secured && !traceCtrl[dtr_pkg::BIT_TRACE_EN] |=> !traceCtrl[dtr_pkg::BIT_TRACE_EN])
    else $error("trace enable set while secured");

  // A write leaves the top two control bits unchanged while secured or armed
  ctrl_hi_guard_a: assert property (
    (doWrite && idx == dtr_pkg::IDX_TRACE_CTRL && avs_byteenable[0] && (secured || armed))
    |=> $stable(traceCtrl[7:6])) else $error("top control bits written while guarded");

  // Low control fields frozen while armed
  ctrl_lo_guard_a: assert property (
    (doWrite && idx == dtr_pkg::IDX_TRACE_CTRL && armed) |=> $stable(traceCtrl[5:0]))
    else $error("low control bits written while armed");

  // Pairing frozen while armed
  pair_guard_a: assert property (
    (armed && !(doWrite && idx == dtr_pkg::IDX_SESSION)) |=> $stable(pairing))
    else $error("pairing changed while armed");

  // Reserved C/D code maps the channels as separate
  cd_separate_a: assert property (
    (pairing[3:2] == 2'b11) |=> matchChannel[3:2] == {$past(cmpD), $past(cmpC)})
    else $error("reserved C/D code not separate");

  // A/B inside code drives channel 0 only
  ab_range_a: assert property (
    (pairing[1:0] == 2'b01) |=> matchChannel[1:0] == {1'b0, $past(abInside)})
    else $error("A/B inside range mapping wrong");

  // Qualifying window read steps the pointer
  ptr_advance_a: assert property (
    (doRead && idx == dtr_pkg::IDX_WINDOW && winReadOk && !unlockWrite) |=> readPtr == $past(readPtr) + PW'(1))
    else $error("pointer did not advance");

  // Refused window read gives zero and keeps the pointer through the answer edge
  bad_read_zero_a: assert property (
    (avs_read && !ack && idx == dtr_pkg::IDX_WINDOW && !winReadOk)
    |=> avs_readdata == 32'h0000_0000 && $stable(readPtr) ##1 $stable(readPtr))
    else $error("refused read not zero");

  // Arming locks and clears full, unless a wrap lands in the same cycle
  arm_locks_a: assert property (
    armWrite |=> locked && (!fullFlag || $past(fullSet)) ##1 locked) else $error("arming did not lock");

  // Unlock returns the pointer to the first word
  unlock_ptr_a: assert property (
    unlockWrite |=> !locked && readPtr == PW'(dtr_pkg::RST_PTR)) else $error("unlock left pointer");

  // Every request answered after exactly one wait cycle
  ack_bound_a: assert property (
    (avs_read || avs_write) && !ack |=> ack && !avs_waitrequest) else $error("answer late");

  // Outside detail mode the filter passes everything
  filter_bypass_a: assert property (
    dtr_pkg::dtr_mode_t'(traceMode) != dtr_pkg::MODE_DETAIL |=> filterPass) else $error("filter outside detail mode");

  // A capture wrap always leaves the full flag set
  full_set_wins_a: assert property (
    fullSet |=> fullFlag) else $error("full flag missed a wrap");

  // Window writes that are not aligned words leave the lock alone
  unlock_word_a: assert property (
    (doWrite && idx == dtr_pkg::IDX_WINDOW && !wordAcc) |=> $stable(locked))
    else $error("unaligned write changed the lock");

  // Main scenarios reached
  cover_unlock_c: cover property (unlockWrite);
  cover_filter_c: cover property (dtr_pkg::dtr_mode_t'(traceMode) == dtr_pkg::MODE_DETAIL && !filterPass);
  cover_line_read_c: cover property (doRead && winReadOk && readPtr[1:0] == 2'b11);
  cover_arm_full_c: cover property (armWrite && fullSet);
  cover_outside_c: cover property (pairing[3:2] == 2'b10 && !cdInside);
endmodule

// file: dtr_pkg.sv
package dtr_pkg;
  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [7:0] IDX_SESSION = 8'h20; // Arm and state register
  localparam logic [7:0] IDX_STATUS = 8'h21; // Full flag register
  localparam logic [7:0] IDX_TRACE_CTRL = 8'h22; // Trace control
  localparam logic [7:0] IDX_PAIRING = 8'h23; // Comparator pairing
  localparam logic [7:0] IDX_WINDOW = 8'h24; // Trace buffer window
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_RESV = 7; // Reserved routing bit of trace control
  localparam int BIT_TRACE_EN = 6; // Trace enable bit
  localparam int POS_RANGE = 4; // Range field low bit
  localparam int POS_MODE = 2; // Trace mode field low bit
  localparam int POS_ALIGN = 0; // Trigger alignment field low bit
  localparam int POS_CD = 2; // C/D pairing field low bit
  localparam int POS_AB = 0; // A/B pairing field low bit
  localparam int BIT_ARM = 0; // Arm bit in session register
  localparam int BIT_SECURE = 1; // Secured state, read only
  localparam int BIT_LOCKED = 2; // Buffer lock, read only
  localparam int BIT_FULL = 7; // Buffer full flag
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_TRACE_CTRL = 8'h00; // Trace control reset
  localparam logic [7:0] RST_PAIRING = 8'h00; // Pairing reset
  localparam logic [7:0] RST_PTR = 8'h00; // First stored trace word
  localparam logic [3:0] BE_LOW_HALF = 4'b0011; // Aligned 16-bit access
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {RANGE_ALL, RANGE_TO_D, RANGE_FROM_C, RANGE_C_D} dtr_range_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_DEDUP, MODE_DETAIL, MODE_PC} dtr_mode_t;
  typedef enum logic [1:0] {ALIGN_END, ALIGN_BEGIN, ALIGN_MID, ALIGN_RESV} dtr_align_t;
  typedef enum logic [1:0] {PAIR_SEPARATE, PAIR_INSIDE, PAIR_OUTSIDE, PAIR_RESV} dtr_pair_t;
endpackage

// file: dtr_capture_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Capture side model
// ----------------------------------------
// Stores trace lines and raises the wrap pulse, as the capture logic would
module dtr_capture_model (
  input wire logic sys_clk, // System clock
  output logic capWrite, // Line store strobe
  output logic [5:0] capAddr, // Line address
  output logic [63:0] capData, // Line data
  output logic fullSet, // Buffer wrapped pulse
  output logic sessionEnd // Session end pulse
);
  // Idle levels at time zero
  initial begin
    capWrite = 1'b0;
    capAddr = 6'h00;
    capData = 64'h0000_0000_0000_0000;
    fullSet = 1'b0;
    sessionEnd = 1'b0;
  end
  // One cycle session end pulse
  task automatic end_session();
    @(posedge sys_clk);
    sessionEnd <= 1'b1;
    @(posedge sys_clk);
    sessionEnd <= 1'b0;
  endtask
  // One store, then inverted lines so a stale value never passes
  task automatic store(input logic [5:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    capWrite <= 1'b1;
    capAddr <= a;
    capData <= d;
    @(posedge sys_clk);
    capWrite <= 1'b0;
    capAddr <= ~a;
    capData <= ~d;
  endtask
  // One cycle wrap pulse
  task automatic wrap();
    @(posedge sys_clk);
    fullSet <= 1'b1;
    @(posedge sys_clk);
    fullSet <= 1'b0;
  endtask
endmodule

// file: debug_trace_control_readout_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Register side bench
// ----------------------------------------
module debug_trace_control_readout_tb;
  localparam logic [63:0] LINE0 = 64'h1111_2222_3333_4444; // First stored line
  localparam logic [63:0] LINE1 = 64'hAAAA_BBBB_CCCC_DDDD; // Second stored line
  logic sys_clk = 1'b0; // 50 MHz clock
  logic reset_n = 1'b0; // Power-on reset
  logic [9:0] avs_address = 10'h000; // Bus address
  logic avs_read = 1'b0; // Bus read
  logic avs_write = 1'b0; // Bus write
  logic [3:0] avs_byteenable = 4'h0; // Bus byte enables
  logic [31:0] avs_writedata = 32'h0000_0000; // Bus write data
  logic [31:0] avs_readdata; // Bus read data
  logic avs_waitrequest; // Bus wait
  logic securePin = 1'b1; // Secured level
  logic [7:0] cmpIn = 8'h00; // Comparator and bound inputs
  logic capWrite; // Store strobe
  logic [5:0] capAddr; // Store line
  logic [63:0] capData; // Store data
  logic fullSet; // Wrap pulse
  logic sessionEnd; // Session end pulse
  logic [3:0] matchChannel; // Match outputs
  logic filterPass; // Filter output
  logic traceEnable; // Enable output
  logic [1:0] traceMode; // Mode output
  logic [1:0] triggerAlign; // Alignment output
  logic armed; // Armed output
  logic [7:0] pairNow; // Pairing last accepted
  int nFail = 0; // Mismatches
  int testsRun = 0; // Comparisons
  int cycles = 0; // Timeout counter
  dtr_readout u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .securePin(securePin), .sessionEnd(sessionEnd),
    .fullSet(fullSet), .capWrite(capWrite), .capAddr(capAddr), .capData(capData), .cmpA(cmpIn[0]),
    .cmpB(cmpIn[1]), .cmpC(cmpIn[2]), .cmpD(cmpIn[3]), .abInside(cmpIn[4]), .cdInside(cmpIn[5]),
    .atOrAboveC(cmpIn[6]), .atOrBelowD(cmpIn[7]), .matchChannel(matchChannel), .filterPass(filterPass),
    .traceEnable(traceEnable), .traceMode(traceMode), .triggerAlign(triggerAlign), .armed(armed));
  dtr_capture_model u_cap (.sys_clk(sys_clk), .capWrite(capWrite), .capAddr(capAddr), .capData(capData),
    .fullSet(fullSet), .sessionEnd(sessionEnd));
  // Clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nFail++;
      close_out();
    end
  end
  // Masked value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    testsRun++;
    if ((got & m) !== (exp & m)) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_byteenable <= be;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    // Waits for the answer; only the hang guard ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, be, wd, rd);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [3:0] be, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] rd;
    bus(1'b0, idx, be, 32'h0000_0000, rd);
    chk(rd, exp, m);
  endtask
  // Expected channel map for one pairing value
  function automatic logic [3:0] expMatch(input logic [7:0] p, input logic [7:0] c);
    logic [1:0] lo;
    logic [1:0] hi;
    lo = (p[1:0] == 2'b01) ? {1'b0, c[4]} : (p[1:0] == 2'b10) ? {1'b0, !c[4]} : c[1:0];
    hi = (p[3:2] == 2'b01) ? {1'b0, c[5]} : (p[3:2] == 2'b10) ? {1'b0, !c[5]} : c[3:2];
    return {hi, lo};
  endfunction
  // Reads the four halfwords of one line
  task automatic read_line(input logic [63:0] d);
    for (int k = 0; k < 4; k++) begin
      rdc(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, {16'h0000, d[16*k +: 16]}, 32'hFFFF_FFFF);
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0006, 32'h0000_0007);
    rdc(dtr_pkg::IDX_PAIRING, 4'h1, 32'h0000_0000, 32'h0000_00FF);
    // Secured: enable bit refused, low fields taken; bit 7 kept clear by software
    wr(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_007F);
    rdc(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_003F, 32'h0000_00FF);
    chk(traceEnable, 1'b0, 32'h1);
    rdc(8'h30, 4'h1, 32'h0000_0000, 32'hFFFF_FFFF);
    securePin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Every range, mode and alignment code; bound above C true, below D false
    cmpIn <= 8'h40;
    for (int t = 0; t < 64; t++) begin
      wr(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_0040 | t);
      repeat (2) @(posedge sys_clk);
      chk(traceMode, t[3:2], 32'h3);
      chk(triggerAlign, t[1:0], 32'h3);
      chk(traceEnable, 1'b1, 32'h1);
      chk(filterPass, (t[3:2] != 2'b10) || (t[5:4] == 2'b00) || (t[5:4] == 2'b10), 32'h1);
    end
    // Every pairing code with two comparator patterns
    for (int p = 0; p < 16; p++) begin
      wr(dtr_pkg::IDX_PAIRING, 4'h1, p);
      rdc(dtr_pkg::IDX_PAIRING, 4'h1, p, 32'h0000_000F);
      for (int s = 0; s < 2; s++) begin
        cmpIn <= s ? 8'hEA : 8'h15;
        repeat (3) @(posedge sys_clk);
        chk(matchChannel, expMatch(p, s ? 8'hEA : 8'h15), 32'hF);
      end
    end
    pairNow = 8'h0F;
    // Readout of two stored lines
    u_cap.store(6'h00, LINE0);
    u_cap.store(6'h01, LINE1);
    u_cap.wrap();
    rdc(dtr_pkg::IDX_STATUS, 4'h1, 32'h0000_0080, 32'h0000_0080);
    rdc(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_5A5A);
    rdc(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0000, 32'h0000_0004);
    read_line(LINE0);
    rdc(dtr_pkg::IDX_WINDOW, 4'h1, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_0000);
    rdc(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_0040);
    read_line(LINE1);
    // Armed: locked, full cleared, guarded writes dropped
    wr(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0001);
    @(posedge sys_clk);
    chk(armed, 1'b1, 32'h1);
    rdc(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0005, 32'h0000_0007);
    rdc(dtr_pkg::IDX_STATUS, 4'h1, 32'h0000_0000, 32'h0000_0080);
    rdc(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(dtr_pkg::IDX_PAIRING, 4'h1, 32'h0000_0005);
    rdc(dtr_pkg::IDX_PAIRING, 4'h1, pairNow, 32'h0000_00FF);
    wr(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_0015);
    rdc(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_0040, 32'h0000_00FF);
    // Capture side ends the session: disarmed, buffer still locked
    u_cap.end_session();
    rdc(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0004, 32'h0000_0005);
    // Disarmed again: still locked until unlocked, then from the first word
    wr(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0000);
    rdc(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(dtr_pkg::IDX_WINDOW, 4'h1, 32'h0000_0000);
    rdc(dtr_pkg::IDX_SESSION, 4'h1, 32'h0000_0004, 32'h0000_0004);
    wr(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_0000);
    read_line(LINE0);
    // Second reset in mid-run keeps the stored lines
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(dtr_pkg::IDX_TRACE_CTRL, 4'h1, 32'h0000_0040);
    wr(dtr_pkg::IDX_WINDOW, dtr_pkg::BE_LOW_HALF, 32'h0000_0000);
    read_line(LINE0);
    close_out();
  end
endmodule
